//--- rtl/pmtis_top.sv
// What this block does
// - Parallel/serial trap enabled: system_mgmt_interrupt on printer and serial three/four ranges.
// - Serial select 10 drops serial one range, 11 drops serial two.
// - Floppy trap enabled: trap primary and secondary floppy port addresses.
// - Primary disk trap enabled: trap ranges picked by primary select bit.
// - Secondary disk idle timer loads, reloads on disk access, signals expiry.
// - Secondary disk trap enabled: trap secondary ranges, set status bit 5.
// - Power timer enable: interrupt on each toggle of timer top bit.
// - Game port enable: interrupt on reads of 200h/201h, status bit 4.
// - Display timer counts down, top bit 6 only, ignores global enable.
// - Retrace enable: interrupt on retrace indication, top bit 5 only.
// - General timer two runs, reload on pin seven, top 9, second 1.
// - General timer one reloads on selected events, expiry at second bit 0.
// - Trap, idle, pin, game and power timer causes show in top bit 0.
// - Trap mirror: disk 0, floppy 1, parallel 2, secondary 5, video 7.
// - Mirror read keeps status; counterpart read returns same and clears.
// - Pin status bits 3..0 for pins seven, five, four, three; 7:5 reserved.
// - Pin sets status only when selected general, input and enabled.
// - Idle mirror flags each device timer expiry at its bit.
// - Device traps act only while global trap enable is set.
`timescale 1ns/1ps
`include "pmtis_defines.svh"
module pmtis_top (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // configuration access
    input wire logic i_cfg_rd,
    input wire logic i_cfg_wr,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [7:0] i_cfg_wdata,
    output logic [7:0] o_cfg_rdata,
    // observed io cycles
    input wire logic i_io_valid,
    input wire logic i_io_write,
    input wire logic [15:0] i_io_addr,
    // configuration held elsewhere
    input wire logic i_pm_enable,
    input wire logic i_global_trap_en,
    input wire logic [1:0] i_serial_sel,
    input wire logic i_pri_disk_sel,
    input wire logic i_sec_disk_sel,
    input wire logic [7:0] i_sec_idle_count,
    input wire logic [7:0] i_vga_count,
    input wire logic [7:0] i_gpt1_count,
    input wire logic [7:0] i_gpt2_count,
    input wire logic [6:0] i_gpt1_event_en,
    input wire logic i_gpt2_pin_reload,
    // events from other logic
    input wire logic [6:0] i_gpt1_events,
    input wire logic i_video_access,
    input wire logic i_retrace,
    input wire logic i_acpi_msb,
    input wire logic [7:0] i_idle_expire,
    // general pins and their setup, index 3..0 = seven, five, four, three
    input wire logic i_gen_pin_seven,
    input wire logic i_gen_pin_five,
    input wire logic i_gen_pin_four,
    input wire logic i_gen_pin_three,
    input wire logic [3:0] i_gpio_is_gpio,
    input wire logic [3:0] i_gpio_is_input,
    input wire logic [3:0] i_gpio_smi_en,
    // top-level reporting
    input wire logic i_top_ack,
    output logic o_smi,
    output logic o_top_bit0,
    output logic o_top_bit5,
    output logic o_top_bit6,
    output logic o_top_bit9,
    output logic [1:0] o_gpt_status
);
    pmtis_pkg::pmtis_top_s st_r;
    pmtis_pkg::pmtis_top_s st_nxt;
    logic [3:0] pin_level;
    logic [3:0] pin_change;
    logic sec_idle_exp;
    logic vga_exp;
    logic gpt1_exp;
    logic gpt2_exp;
    logic sec_hit;
    logic gpt1_reload;
    logic gpt2_reload;

    // inclusive io range test
    function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction : in_rng

    // disk range test; select adds the control block pair
    function automatic logic disk_hit(input logic [15:0] a, input logic [15:0] cmd,
                                      input logic [15:0] ctl, input logic sel);
        disk_hit = in_rng(a, cmd, cmd + 16'h0007) || (sel && in_rng(a, ctl, ctl + 16'h0001));
    endfunction : disk_hit

    // pins pass three flops before use
    pmtis_sync u_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_pin({i_gen_pin_seven, i_gen_pin_five, i_gen_pin_four, i_gen_pin_three}),
        .o_level(pin_level),
        .o_change(pin_change)
    );

    // timer reload sources
    assign sec_hit = i_io_valid && disk_hit(i_io_addr, 16'h0170, 16'h0376, i_sec_disk_sel);
    assign gpt1_reload = |(i_gpt1_events & i_gpt1_event_en);
    assign gpt2_reload = i_gpt2_pin_reload && pin_change[3] && pin_level[3];

    // secondary disk idle timer
    pmtis_timer u_sec_idle (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_en(st_r.tmr_en[`PMTIS_T_SEC_IDLE]),
        .i_reload(sec_hit),
        .i_tick(st_r.tick),
        .i_load(i_sec_idle_count),
        .o_expire(sec_idle_exp)
    );

    // display timer; a new count needs an enable low-high cycle by software
    pmtis_timer u_vga (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_en(st_r.tmr_en[`PMTIS_T_VGA]),
        .i_reload(1'b0),
        .i_tick(st_r.tick),
        .i_load(i_vga_count),
        .o_expire(vga_exp)
    );

    // general timer one
    pmtis_timer u_gpt1 (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_en(st_r.tmr_en[`PMTIS_T_GPT1]),
        .i_reload(gpt1_reload),
        .i_tick(st_r.tick),
        .i_load(i_gpt1_count),
        .o_expire(gpt1_exp)
    );

    // general timer two
    pmtis_timer u_gpt2 (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_en(st_r.tmr_en[`PMTIS_T_GPT2]),
        .i_reload(gpt2_reload),
        .i_tick(st_r.tick),
        .i_load(i_gpt2_count),
        .o_expire(gpt2_exp)
    );

    // traps, status capture, register access and interrupt output
    always_comb
    begin
        logic [15:0] a;
        logic acc;
        logic trap_go;
        logic [7:0] trap_set;
        logic [7:0] misc_set;
        logic [7:0] idle_set;
        logic ser_hit;
        logic [3:0] pin_ok;
        a = i_io_addr;
        acc = i_io_valid;
        trap_go = acc && i_global_trap_en;
        trap_set = 8'h00;
        misc_set = 8'h00;
        idle_set = 8'h00;
        ser_hit = 1'b0;
        pin_ok = 4'h0;
        st_nxt = st_r;
        // printer and serial ranges, serial one/two droppable by select
        ser_hit = in_rng(a, 16'h0378, 16'h037F) || in_rng(a, 16'h0778, 16'h077A)
            || in_rng(a, 16'h0278, 16'h027F) || in_rng(a, 16'h0678, 16'h067A)
            || in_rng(a, 16'h03E8, 16'h03EF) || in_rng(a, 16'h02E8, 16'h02EF);
        if (in_rng(a, 16'h03F8, 16'h03FF) && (i_serial_sel != `PMTIS_SER_DROP_ONE))
            ser_hit = 1'b1;
        if (in_rng(a, 16'h02F8, 16'h02FF) && (i_serial_sel != `PMTIS_SER_DROP_TWO))
            ser_hit = 1'b1;
        trap_set[`PMTIS_B_PAR_SER] = trap_go && st_r.trap_en[`PMTIS_B_PAR_SER] && ser_hit;
        trap_set[`PMTIS_B_FLOPPY] = trap_go && st_r.trap_en[`PMTIS_B_FLOPPY]
            && ((a == 16'h03F2) || (a == 16'h03F4) || (a == 16'h03F5) || (a == 16'h03F7)
            || (a == 16'h0372) || (a == 16'h0373) || (a == 16'h0375)
            || (a == 16'h0377));
        trap_set[`PMTIS_B_PRI_DISK] = trap_go && st_r.trap_en[`PMTIS_B_PRI_DISK]
            && disk_hit(a, 16'h01F0, 16'h03F6, i_pri_disk_sel);
        trap_set[`PMTIS_B_KBD] = trap_go && st_r.trap_en[`PMTIS_B_KBD]
            && ((a == 16'h0060) || (a == 16'h0064));
        trap_set[`PMTIS_B_SEC_TRAP] = trap_go && st_r.tmr_en[`PMTIS_T_SEC_TRAP]
            && disk_hit(a, 16'h0170, 16'h0376, i_sec_disk_sel);
        trap_set[`PMTIS_B_VIDEO] = i_global_trap_en && i_video_access
            && st_r.trap_en[`PMTIS_B_VIDEO];
        trap_set[`PMTIS_B_SEC_IDLE] = sec_idle_exp;
        // pins count only when general, input and enabled
        pin_ok = i_gpio_is_gpio & i_gpio_is_input & i_gpio_smi_en;
        misc_set[3:0] = pin_change & pin_ok;
        misc_set[`PMTIS_M_GAME] = acc && !i_io_write && st_r.tmr_en[`PMTIS_T_GAME]
            && in_rng(a, 16'h0200, 16'h0201);
        idle_set = i_idle_expire;
        // global power management enable blocks trap, misc and idle status events
        if (!i_pm_enable)
        begin
            trap_set = 8'h00;
            misc_set = 8'h00;
            idle_set = 8'h00;
        end
        // register writes
        if (i_cfg_wr && (i_cfg_addr == `PMTIS_IDX_TRAP_EN))
            st_nxt.trap_en = i_cfg_wdata;
        if (i_cfg_wr && (i_cfg_addr == `PMTIS_IDX_TMR_EN))
            st_nxt.tmr_en = i_cfg_wdata;
        // read data: mirror and counterpart return the same byte
        case (i_cfg_addr)
            `PMTIS_IDX_TRAP_EN: st_nxt.rdata = st_r.trap_en;
            `PMTIS_IDX_TMR_EN: st_nxt.rdata = st_r.tmr_en;
            `PMTIS_IDX_MISC_ST, `PMTIS_IDX_MISC_CLR: st_nxt.rdata = st_r.misc_st;
            `PMTIS_IDX_IDLE_ST, `PMTIS_IDX_IDLE_CLR: st_nxt.rdata = st_r.idle_st;
            `PMTIS_IDX_TRAP_ST, `PMTIS_IDX_TRAP_CLR: st_nxt.rdata = st_r.trap_st;
            default: st_nxt.rdata = `PMTIS_RST_BYTE;
        endcase
        if (!i_cfg_rd)
            st_nxt.rdata = st_r.rdata;
        // sticky status; the counterpart read clears, a same-cycle event wins
        if (i_cfg_rd && (i_cfg_addr == `PMTIS_IDX_MISC_CLR))
            st_nxt.misc_st = 8'h00;
        if (i_cfg_rd && (i_cfg_addr == `PMTIS_IDX_IDLE_CLR))
            st_nxt.idle_st = 8'h00;
        if (i_cfg_rd && (i_cfg_addr == `PMTIS_IDX_TRAP_CLR))
            st_nxt.trap_st = 8'h00;
        st_nxt.misc_st = (st_nxt.misc_st | misc_set) & ~`PMTIS_M_RSVD_MASK;
        st_nxt.idle_st = st_nxt.idle_st | idle_set;
        st_nxt.trap_st = (st_nxt.trap_st | trap_set) & ~`PMTIS_TRAP_RSVD_MASK;
        // top-level only causes, cleared together by the handler ack
        st_nxt.acpi_prev = i_acpi_msb;
        st_nxt.retr_prev = i_retrace;
        if (i_top_ack)
        begin
            st_nxt.acpi_st = 1'b0;
            st_nxt.retr_st = 1'b0;
            st_nxt.vga_st = 1'b0;
            st_nxt.gpt_st = 2'b00;
        end
        if (i_pm_enable && st_r.tmr_en[`PMTIS_T_ACPI] && (i_acpi_msb != st_r.acpi_prev))
            st_nxt.acpi_st = 1'b1;
        if (st_r.tmr_en[`PMTIS_T_RETRACE] && i_retrace && !st_r.retr_prev)
            st_nxt.retr_st = 1'b1;
        if (vga_exp)
            st_nxt.vga_st = 1'b1;
        if (gpt1_exp)
            st_nxt.gpt_st[0] = 1'b1;
        if (gpt2_exp)
            st_nxt.gpt_st[1] = 1'b1;
        // timebase divider for the timers
        st_nxt.tick = (st_r.tick_cnt == 7'h00);
        st_nxt.tick_cnt = st_nxt.tick ? 7'((`PMTIS_TICK_CYC) - 1) : st_r.tick_cnt - 7'h01;
        // outputs: top0 and smi one cycle behind the status flops, top9 in step with gpt_st
        st_nxt.top0 = (|st_r.trap_st) || (|st_r.idle_st) || (|st_r.misc_st)
            || st_r.acpi_st;
        st_nxt.smi = st_nxt.top0 || st_r.retr_st || st_r.vga_st || (|st_r.gpt_st);
        st_nxt.top9 = |st_nxt.gpt_st;
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flops
    assign o_cfg_rdata = st_r.rdata;
    assign o_smi = st_r.smi;
    assign o_top_bit0 = st_r.top0;
    assign o_top_bit5 = st_r.retr_st;
    assign o_top_bit6 = st_r.vga_st;
    assign o_top_bit9 = st_r.top9;
    assign o_gpt_status = st_r.gpt_st;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    sequence floppy_access_s;
        i_io_valid && (i_io_addr == 16'h03F2) && i_global_trap_en && i_pm_enable
            && st_r.trap_en[`PMTIS_B_FLOPPY];
    endsequence
    sequence trap_cleared_s;
        i_cfg_rd && (i_cfg_addr == `PMTIS_IDX_TRAP_CLR) && !i_io_valid && !i_video_access
            && !sec_idle_exp;
    endsequence

    floppy_trap_a: assert property (floppy_access_s |=> st_r.trap_st[1] ##1 o_smi)
        else $error("floppy access did not raise status and interrupt");
    counter_clear_a: assert property (trap_cleared_s |=> st_r.trap_st == 8'h00
        && o_cfg_rdata == $past(st_r.trap_st))
        else $error("counterpart read did not clear or return status");
    mirror_keep_a: assert property (i_cfg_rd && i_cfg_addr == `PMTIS_IDX_IDLE_ST
        |=> st_r.idle_st == ($past(st_r.idle_st)
        | ($past(i_idle_expire) & {8{$past(i_pm_enable)}})))
        else $error("mirror read changed idle status");
    serial_drop_a: assert property (i_io_valid && i_io_addr == 16'h03F8
        && i_serial_sel == `PMTIS_SER_DROP_ONE && !st_r.trap_st[2] |=> !st_r.trap_st[2])
        else $error("dropped serial range still trapped");
    game_read_a: assert property (i_io_valid && !i_io_write && i_io_addr == 16'h0201
        && i_pm_enable && st_r.tmr_en[`PMTIS_T_GAME] |=> st_r.misc_st[4])
        else $error("game port read not flagged");
    trap_gate_a: assert property ($rose(st_r.trap_st[0]) |-> $past(i_global_trap_en))
        else $error("trap set while global trap enable low");
    pin_gate_a: assert property ($rose(st_r.misc_st[0])
        |-> $past(i_gpio_is_gpio[0] && i_gpio_is_input[0] && i_gpio_smi_en[0]))
        else $error("pin status set while not configured");
    acpi_toggle_a: assert property (i_pm_enable && st_r.tmr_en[`PMTIS_T_ACPI]
        && i_acpi_msb != st_r.acpi_prev && !i_top_ack |=> st_r.acpi_st ##1 o_top_bit0)
        else $error("timer top bit toggle missed");
    sticky_hold_a: assert property (st_r.trap_st[0] && !(i_cfg_rd
        && i_cfg_addr == `PMTIS_IDX_TRAP_CLR) |=> st_r.trap_st[0])
        else $error("trap status dropped without clearing read");
    rsvd_zero_a: assert property (st_r.misc_st[7:5] == 3'h0 && !st_r.trap_st[6])
        else $error("reserved status bits set");
    vga_top_a: assert property (vga_exp |=> o_top_bit6 && !$changed(o_top_bit0))
        else $error("display timer expiry misreported");
endmodule : pmtis_top

//--- rtl/pmtis_defines.svh
`ifndef PMTIS_DEFINES_SVH
`define PMTIS_DEFINES_SVH

// configuration register indices
`define PMTIS_IDX_TRAP_EN 8'h82
`define PMTIS_IDX_TMR_EN 8'h83
`define PMTIS_IDX_MISC_ST 8'h84
`define PMTIS_IDX_IDLE_ST 8'h85
`define PMTIS_IDX_TRAP_ST 8'h86
`define PMTIS_IDX_MISC_CLR 8'hF4
`define PMTIS_IDX_IDLE_CLR 8'hF5
`define PMTIS_IDX_TRAP_CLR 8'hF6
`define PMTIS_RST_BYTE 8'h00

// trap enable fields, trap status shares these positions; bits 4 and 5 are status only, their enables sit in the timer enable register
`define PMTIS_B_PRI_DISK 0
`define PMTIS_B_FLOPPY 1
`define PMTIS_B_PAR_SER 2
`define PMTIS_B_KBD 3
`define PMTIS_B_SEC_IDLE 4
`define PMTIS_B_SEC_TRAP 5
`define PMTIS_B_VIDEO 7

// timer enable fields
`define PMTIS_T_GPT1 0
`define PMTIS_T_GPT2 1
`define PMTIS_T_RETRACE 2
`define PMTIS_T_VGA 3
`define PMTIS_T_GAME 4
`define PMTIS_T_ACPI 5
`define PMTIS_T_SEC_TRAP 6
`define PMTIS_T_SEC_IDLE 7

// misc status fields
`define PMTIS_M_GAME 4
`define PMTIS_M_RSVD_MASK 8'hE0
`define PMTIS_TRAP_RSVD_MASK 8'h40

// serial select codes that drop a serial range from the trap
`define PMTIS_SER_DROP_ONE 2'b10
`define PMTIS_SER_DROP_TWO 2'b11

// timer timebase
`define PMTIS_CLK_NS 8
`define PMTIS_TICK_NS 1000
`define PMTIS_TICK_CYC ((`PMTIS_TICK_NS) / (`PMTIS_CLK_NS))

`endif

//--- rtl/pmtis_pkg.sv
package pmtis_pkg;

    // state of the top module
    typedef struct packed {
        logic [7:0] trap_en;
        logic [7:0] tmr_en;
        logic [7:0] misc_st;
        logic [7:0] idle_st;
        logic [7:0] trap_st;
        logic acpi_prev;
        logic retr_prev;
        logic acpi_st;
        logic retr_st;
        logic vga_st;
        logic [1:0] gpt_st;
        logic [6:0] tick_cnt;
        logic tick;
        logic [7:0] rdata;
        logic smi;
        logic top0;
        logic top9;
    } pmtis_top_s;

    // state of one down counter
    typedef struct packed {
        logic en_prev;
        logic live;
        logic [7:0] cnt;
        logic expire;
    } pmtis_timer_s;

    // state of the pin synchroniser
    typedef struct packed {
        logic [3:0] f1;
        logic [3:0] f2;
        logic [3:0] f3;
        logic [3:0] stab;
        logic [3:0] chg;
    } pmtis_sync_s;

endpackage : pmtis_pkg

//--- rtl/pmtis_timer.sv
`timescale 1ns/1ps
// 8-bit down counter: loads on enable, reloads on request, pulses on expiry
module pmtis_timer (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // control
    input wire logic i_en,
    input wire logic i_reload,
    input wire logic i_tick,
    input wire logic [7:0] i_load,
    // event
    output logic o_expire
);
    pmtis_pkg::pmtis_timer_s st_r;
    pmtis_pkg::pmtis_timer_s st_nxt;

    // stop at zero after expiry so one idle period gives one event
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.expire = 1'b0;
        st_nxt.en_prev = i_en;
        if (!i_en)
        begin
            st_nxt.live = 1'b0;
        end
        else if (!st_r.en_prev || i_reload)
        begin
            st_nxt.cnt = i_load;
            st_nxt.live = 1'b1;
        end
        else if (st_r.live && i_tick)
        begin
            if (st_r.cnt <= 8'h01)
            begin
                st_nxt.cnt = 8'h00;
                st_nxt.live = 1'b0;
                st_nxt.expire = 1'b1;
            end
            else
            begin
                st_nxt.cnt = st_r.cnt - 8'h01;
            end
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign o_expire = st_r.expire;
endmodule : pmtis_timer

//--- rtl/pmtis_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser for the four general pins with change pulse
module pmtis_sync (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // pins
    input wire logic [3:0] i_pin,
    // synchronised view
    output logic [3:0] o_level,
    output logic [3:0] o_change
);
    pmtis_pkg::pmtis_sync_s st_r;
    pmtis_pkg::pmtis_sync_s st_nxt;

    // f1 feeds only f2; a change counts once f2 and f3 agree
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.f1 = i_pin;
        st_nxt.f2 = st_r.f1;
        st_nxt.f3 = st_r.f2;
        st_nxt.stab = (st_r.f2 & st_r.f3) | (st_r.stab & (st_r.f2 ^ st_r.f3));
        st_nxt.chg = st_nxt.stab ^ st_r.stab;
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign o_level = st_r.stab;
    assign o_change = st_r.chg;
endmodule : pmtis_sync

//--- verif/pmtis_host.sv
`timescale 1ns/1ps
// host model: one config strobe per access, idle bus shows inverse
module pmtis_host (
    // clock
    input wire logic i_clk,
    // config bus
    output logic o_rd,
    output logic o_wr,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata
);
    // idle bus at time zero
    initial
    begin
        {o_rd, o_wr, o_addr, o_wdata} = 18'h0_0000;
    end
    // single byte write, strobe held for one edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        {o_addr, o_wdata, o_wr} = {a, d, 1'b1};
        @(posedge i_clk);
        #1;
        {o_addr, o_wdata, o_wr} = {~a, ~d, 1'b0};
    endtask : wr
    // single byte read; data taken after it has landed, it holds anyway
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        #1;
        {o_addr, o_rd} = {a, 1'b1};
        @(posedge i_clk);
        #1;
        {o_addr, o_rd} = {~a, 1'b0};
        @(posedge i_clk);
        #1;
        d = i_rdata;
    endtask : rd
    // display timer restart: stop first so the new count is loaded
    task automatic vga_restart(input logic [7:0] other);
        wr(8'h83, other);
        wr(8'h83, other | 8'h08);
    endtask : vga_restart
endmodule : pmtis_host

//--- verif/test_pm_trap_idle_smi_sources.sv
`timescale 1ns/1ps
// bench for the trap, idle, pin and timer event sources
module test_pm_trap_idle_smi_sources;
    logic clk, rst_b, cfg_rd, cfg_wr, io_valid, io_write, pm_en, gte, g2_rel, vid, retr, acpi;
    logic ack, smi, tb0, tb5, tb6, tb9, pri_sel, sec_sel;
    logic [1:0] ser, gst;
    logic [3:0] gp, is_gp, is_in, gp_en;
    logic [6:0] ev_en, ev;
    logic [7:0] addr, wdata, rdata, idle_cnt, vga_cnt, g1_cnt, g2_cnt, idle_exp;
    logic [15:0] io_addr;
    int n_mismatch = 0;
    int cmp_count = 0;
    // trap table: address, serial select, expected clearing read
    logic [15:0] ta [13] = '{16'h03F2, 16'h0377, 16'h03F3, 16'h037F, 16'h0278, 16'h03E8,
        16'h03F8, 16'h03F8, 16'h02F8, 16'h02F8, 16'h01F0, 16'h0170, 16'h0060};
    logic [1:0] ts [13] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h3, 2'h2,
        2'h0, 2'h0, 2'h0};
    logic [7:0] te [13] = '{8'h02, 8'h02, 8'h00, 8'h04, 8'h04, 8'h04, 8'h00, 8'h04, 8'h00,
        8'h04, 8'h01, 8'h20, 8'h08};

    pmtis_host u_pmtis_host (.i_clk(clk), .o_rd(cfg_rd), .o_wr(cfg_wr), .o_addr(addr),
        .o_wdata(wdata), .i_rdata(rdata));
    pmtis_top u_pmtis_top (
        .i_clk(clk), .i_rst_b(rst_b), .i_cfg_rd(cfg_rd), .i_cfg_wr(cfg_wr),
        .i_cfg_addr(addr), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata),
        .i_io_valid(io_valid), .i_io_write(io_write), .i_io_addr(io_addr),
        .i_pm_enable(pm_en), .i_global_trap_en(gte), .i_serial_sel(ser),
        .i_pri_disk_sel(pri_sel), .i_sec_disk_sel(sec_sel), .i_sec_idle_count(idle_cnt),
        .i_vga_count(vga_cnt), .i_gpt1_count(g1_cnt), .i_gpt2_count(g2_cnt),
        .i_gpt1_event_en(ev_en), .i_gpt2_pin_reload(g2_rel), .i_gpt1_events(ev),
        .i_video_access(vid), .i_retrace(retr), .i_acpi_msb(acpi), .i_idle_expire(idle_exp),
        .i_gen_pin_seven(gp[3]), .i_gen_pin_five(gp[2]), .i_gen_pin_four(gp[1]),
        .i_gen_pin_three(gp[0]), .i_gpio_is_gpio(is_gp), .i_gpio_is_input(is_in),
        .i_gpio_smi_en(gp_en), .i_top_ack(ack), .o_smi(smi), .o_top_bit0(tb0),
        .o_top_bit5(tb5), .o_top_bit6(tb6), .o_top_bit9(tb9), .o_gpt_status(gst));

    // free running clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_pmtis_host.rd(a, d);
        check(what, d, exp);
    endtask : rdc

    // all tasks start and end 1 ns after an edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    // one io cycle, then room for the status to land
    task automatic io(input logic [15:0] a, input logic w);
        {io_addr, io_write, io_valid} = {a, w, 1'b1};
        cyc(1);
        io_valid = 1'b0;
        cyc(2);
    endtask : io

    task automatic ack_top;
        ack = 1'b1;
        cyc(1);
        ack = 1'b0;
        cyc(3);
    endtask : ack_top

    task automatic t_regs;
        for (int i = 0; i < 5; i++)
            rdc("reset value", 8'h82 + 8'(i), 8'h00);
        u_pmtis_host.wr(8'h86, 8'hFF);
        rdc("read-only mirror", 8'h86, 8'h00);
        u_pmtis_host.wr(8'h82, 8'h8F);
        rdc("trap enable", 8'h82, 8'h8F);
        rdc("unmapped", 8'h90, 8'h00);
    endtask : t_regs

    task automatic t_traps;
        u_pmtis_host.wr(8'h83, 8'h40);
        for (int i = 0; i < 13; i++)
        begin
            ser = ts[i];
            io(ta[i], 1'b0);
            rdc("trap status", 8'hF6, te[i]);
        end
        {ser, pri_sel, sec_sel} = 4'h3;
        io(16'h03F6, 1'b1);
        io(16'h0376, 1'b0);
        rdc("disk select ranges", 8'hF6, 8'h21);
        vid = 1'b1;
        cyc(1);
        vid = 1'b0;
        io(16'h03F4, 1'b1);
        rdc("mirror keeps", 8'h86, 8'h82);
        check("top bit0", tb0, 8'h01);
        check("smi", smi, 8'h01);
        rdc("clearing read", 8'hF6, 8'h82);
        rdc("after clear", 8'h86, 8'h00);
        gte = 1'b0;
        io(16'h03F2, 1'b0);
        rdc("global trap off", 8'hF6, 8'h00);
        gte = 1'b1;
    endtask : t_traps

    // mid-run reset drops held status and enables
    task automatic t_reset;
        io(16'h0378, 1'b0);
        rdc("held before reset", 8'h86, 8'h04);
        rst_b = 1'b0;
        cyc(2);
        rst_b = 1'b1;
        rdc("reset clears status", 8'h86, 8'h00);
        rdc("reset clears enable", 8'h82, 8'h00);
    endtask : t_reset

    task automatic t_events;
        u_pmtis_host.wr(8'h83, 8'h10);
        io(16'h0201, 1'b0);
        rdc("game read", 8'hF4, 8'h10);
        io(16'h0200, 1'b1);
        rdc("game write", 8'hF4, 8'h00);
        {is_gp, is_in, gp_en} = 12'hFFF;
        for (int i = 0; i < 4; i++)
        begin
            gp[i] = ~gp[i];
            cyc(8);
            rdc("pin status", 8'hF4, 8'h01 << i);
        end
        is_in = 4'hE;
        gp[0] = ~gp[0];
        cyc(8);
        rdc("pin not input", 8'hF4, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            idle_exp[i] = 1'b1;
            cyc(1);
            idle_exp[i] = 1'b0;
            rdc("idle status", 8'hF5, 8'h01 << i);
        end
    endtask : t_events

    task automatic t_top;
        u_pmtis_host.wr(8'h83, 8'h24);
        acpi = 1'b1;
        cyc(4);
        check("power timer rise", tb0, 8'h01);
        ack_top();
        check("cause acked", tb0, 8'h00);
        acpi = 1'b0;
        cyc(4);
        check("power timer fall", tb0, 8'h01);
        ack_top();
        retr = 1'b1;
        cyc(4);
        check("retrace", {tb5, tb0}, 8'h02);
        ack_top();
    endtask : t_top

    task automatic t_timers;
        pm_en = 1'b0;
        vga_cnt = 8'h01;
        u_pmtis_host.vga_restart(8'h00);
        for (int i = 0; i < 800 && tb6 !== 1'b1; i++)
            cyc(1);
        check("display timer", tb6, 8'h01);
        {pm_en, ev_en} = 8'h81;
        u_pmtis_host.wr(8'h83, 8'h01);
        repeat (6)
        begin
            cyc(100);
            ev[0] = 1'b1;
            cyc(1);
            ev[0] = 1'b0;
        end
        check("timer one reloaded", gst, 8'h00);
        for (int i = 0; i < 800 && gst[0] !== 1'b1; i++)
            cyc(1);
        check("timer one expired", gst, 8'h01);
        g2_rel = 1'b1;
        u_pmtis_host.wr(8'h83, 8'h02);
        repeat (3)
        begin
            cyc(50);
            gp[3] = 1'b0;
            cyc(50);
            gp[3] = 1'b1;
        end
        cyc(8);
        check("timer two reloaded", gst, 8'h01);
        for (int i = 0; i < 800 && gst[1] !== 1'b1; i++)
            cyc(1);
        check("timer two", {tb9, gst}, 8'h07);
        rdc("pin seven status", 8'hF4, 8'h08);
        ack_top();
        u_pmtis_host.wr(8'h83, 8'h80);
        for (int i = 0; i < 800 && tb0 !== 1'b1; i++)
            cyc(1);
        rdc("secondary idle", 8'hF6, 8'h10);
    endtask : t_timers

    task automatic summarize;
        $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    // main sequence; inputs change 1 ns after the edge
    initial
    begin
        {rst_b, io_valid, io_write, g2_rel, vid, retr, acpi, ack, pri_sel, sec_sel} = 10'h000;
        {pm_en, gte} = 2'h3;
        {ser, gp, is_gp, is_in, gp_en, ev_en, ev, idle_exp, io_addr} = 56'h0;
        {idle_cnt, vga_cnt, g1_cnt, g2_cnt} = 32'h0202_0202;
        repeat (6) @(posedge clk);
        #1;
        rst_b = 1'b1;
        t_regs();
        t_traps();
        t_reset();
        t_events();
        t_top();
        t_timers();
        summarize();
    end

    // cut a hang short, several times the expected run
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("watchdog expired");
        summarize();
    end
endmodule : test_pm_trap_idle_smi_sources
